// ---- rtl/dsa_access_unit.sv ----
// data space access unit: x/y address generation, byte lanes, alignment trap, dma ram port
`timescale 1ns/1ps
`default_nettype none
`include "dsa_regs.svh"

module dsa_access_unit #(
  parameter logic [15:0] RAM_BYTES = `DSA_RAM_BYTES,
  parameter logic [15:0] Y_BASE = `DSA_Y_BASE
) (
  input wire logic clk_sys,
  input wire logic nrst,
  // x port: unified access and x prefetch
  input wire logic x_req,
  input wire logic x_write,
  input wire logic x_byte,
  input wire dsa_pkg::dsa_amode_t x_amode,
  input wire logic [15:0] x_direct_addr,
  input wire logic [3:0] x_ptr_sel,
  input wire logic [15:0] x_wdata,
  input wire logic x_load_en,
  input wire logic [3:0] x_load_sel,
  // extend operations on a working register
  input wire dsa_pkg::dsa_ext_t ext_op,
  input wire logic [3:0] ext_sel,
  // y port: second read path
  input wire logic y_req,
  input wire logic [3:0] y_ptr_sel,
  input wire logic y_postinc,
  // address generator configuration
  input wire logic x_mod_en,
  input wire logic [15:0] x_mod_start,
  input wire logic [15:0] x_mod_end,
  input wire logic y_mod_en,
  input wire logic [15:0] y_mod_start,
  input wire logic [15:0] y_mod_end,
  input wire logic x_brev_en,
  input wire logic [14:0] x_brev_step,
  // dma controller port
  input wire logic dma_req,
  input wire logic dma_write,
  input wire logic [`DSA_DMA_WORD_BITS-1:0] dma_word,
  input wire logic [1:0] dma_be,
  input wire logic [15:0] dma_wdata,
  // results
  output logic [15:0] x_rdata,
  output logic x_rvalid,
  output logic [15:0] y_rdata,
  output logic y_rvalid,
  output logic [15:0] dma_rdata,
  output logic dma_rvalid,
  output logic addr_err,
  output logic addr_err_wr,
  output logic psv_sel,
  output logic [14:0] psv_addr
);

  // ==========================================================
  // sizes
  localparam int RAM_WORDS = int'(RAM_BYTES) / 2;
  localparam int AW = $clog2(RAM_WORDS);
  localparam logic [15:0] RAM_END = `DSA_RAM_BASE + RAM_BYTES;
  localparam logic [15:0] DMA_BASE = RAM_END - `DSA_DMA_BYTES;

  // ==========================================================
  // storage: two byte-wide halves
  logic [7:0] mem_lo [RAM_WORDS];
  logic [7:0] mem_hi [RAM_WORDS];

  dsa_pkg::dsa_state_t st_ff;
  dsa_pkg::dsa_state_t nxt_st;

  // memory write strobes from the combinational section
  logic cpu_we_lo;
  logic cpu_we_hi;
  logic [AW-1:0] cpu_widx;
  logic [15:0] cpu_wword;
  logic dma_we_lo;
  logic dma_we_hi;
  logic [AW-1:0] dma_idx;

  // ==========================================================
  // helper functions

  // word index of a ram byte address
  function automatic logic [AW-1:0] ram_idx(input logic [15:0] a);
    logic [15:0] o;
    o = a - `DSA_RAM_BASE;
    ram_idx = o[AW:1];
  endfunction

  // region decode of an effective address
  function automatic dsa_pkg::dsa_region_t region_of(input logic [15:0] a);
    if (a[15])
      region_of = dsa_pkg::RG_PSV;
    else if (a <= `DSA_SPEC_LAST)
      region_of = dsa_pkg::RG_SPEC;
    else if (a < RAM_END)
      region_of = dsa_pkg::RG_RAM;
    else
      region_of = dsa_pkg::RG_NONE;
  endfunction

  // working register hit: {hit, index}
  function automatic logic [4:0] wreg_map(input logic [15:0] a);
    case ({a[15:1], 1'b0})
      `DSA_WORK_REG_0_OFS: wreg_map = 5'h10;
      `DSA_WORK_REG_1_OFS: wreg_map = 5'h11;
      `DSA_WORK_REG_2_OFS: wreg_map = 5'h12;
      `DSA_WORK_REG_3_OFS: wreg_map = 5'h13;
      `DSA_WORK_REG_4_OFS: wreg_map = 5'h14;
      `DSA_WORK_REG_5_OFS: wreg_map = 5'h15;
      `DSA_WORK_REG_6_OFS: wreg_map = 5'h16;
      `DSA_WORK_REG_7_OFS: wreg_map = 5'h17;
      `DSA_WORK_REG_8_OFS: wreg_map = 5'h18;
      `DSA_WORK_REG_9_OFS: wreg_map = 5'h19;
      `DSA_WORK_REG_10_OFS: wreg_map = 5'h1a;
      default: wreg_map = 5'h00;
    endcase
  endfunction

  // linear step with optional modulo wrap
  function automatic logic [15:0] mod_next(input logic [15:0] p, input logic [15:0] step,
                                           input logic en, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] n;
    n = p + step;
    if (en && (n > hi))
      n = lo;
    mod_next = n;
  endfunction

  // reverse-carry add on the word address bits
  function automatic logic [15:0] brev_next(input logic [15:0] p, input logic [14:0] m);
    logic [14:0] ra;
    logic [14:0] rm;
    logic [14:0] s;
    logic [14:0] r;
    for (int i = 0; i < 15; i++)
    begin
      ra[i] = p[15-i];
      rm[i] = m[14-i];
    end
    s = ra + rm;
    for (int i = 0; i < 15; i++)
    begin
      r[i] = s[14-i];
    end
    brev_next = {r, p[0]};
  endfunction

  // read one aligned word as the x side sees it
  function automatic logic [15:0] word_at(input logic [15:0] a, input dsa_pkg::dsa_state_t s,
                                          input logic [15:0] ram_word);
    logic [4:0] wm;
    wm = wreg_map(a);
    if (wm[4])
      word_at = s.wreg[wm[3:0]];
    else if (region_of(a) == dsa_pkg::RG_RAM)
      word_at = ram_word;
    else
      word_at = 16'h0000;
  endfunction

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic [15:0] x_ptr;
    logic [15:0] x_eba;
    logic [15:0] x_word;
    logic [15:0] x_val;
    logic [4:0] x_wm;
    logic x_misalign;
    logic x_wr_ok;
    logic lane_lo;
    logic lane_hi;
    logic [15:0] y_eba;
    logic [15:0] y_word;
    logic [15:0] ext_src;
    x_ptr = '0;
    x_eba = '0;
    x_word = '0;
    x_val = '0;
    x_wm = '0;
    x_misalign = 1'b0;
    x_wr_ok = 1'b0;
    lane_lo = 1'b0;
    lane_hi = 1'b0;
    y_eba = '0;
    y_word = '0;
    ext_src = '0;
    nxt_st = st_ff;
    nxt_st.x_rvalid = 1'b0;
    nxt_st.y_rvalid = 1'b0;
    nxt_st.dma_rvalid = 1'b0;
    nxt_st.addr_err = 1'b0;
    nxt_st.psv_sel = 1'b0;
    cpu_we_lo = 1'b0;
    cpu_we_hi = 1'b0;
    cpu_widx = '0;
    cpu_wword = '0;
    dma_we_lo = 1'b0;
    dma_we_hi = 1'b0;
    dma_idx = '0;

    // x effective address: direct, near field or pointer
    x_ptr = st_ff.wreg[x_ptr_sel];
    case (x_amode)
      dsa_pkg::AM_DIRECT16: x_eba = x_direct_addr;
      dsa_pkg::AM_NEAR13: x_eba = {3'h0, x_direct_addr[`DSA_NEAR_BITS-1:0]};
      default: x_eba = x_ptr;
    endcase
    x_wm = wreg_map(x_eba);
    x_word = word_at(x_eba, st_ff, {mem_hi[ram_idx(x_eba)], mem_lo[ram_idx(x_eba)]});
    x_misalign = x_req && !x_byte && x_eba[0];

    // x read: byte picked by address bit zero onto low lane
    if (x_byte)
      x_val = {8'h00, x_eba[0] ? x_word[15:8] : x_word[7:0]};
    else
      x_val = x_word;
    if (x_req && !x_write)
    begin
      nxt_st.x_rdata = x_val;
      nxt_st.x_rvalid = 1'b1;
    end

    // program view window
    if (x_req && region_of(x_eba) == dsa_pkg::RG_PSV && !x_wm[4])
    begin
      nxt_st.psv_sel = 1'b1;
      nxt_st.psv_addr = x_eba[14:0];
    end

    // trap pulse with direction
    if (x_misalign)
    begin
      nxt_st.addr_err = 1'b1;
      nxt_st.addr_err_wr = x_write;
    end

    // x write through the unified range, lane strobes
    x_wr_ok = x_req && x_write && !x_misalign;
    lane_lo = x_byte ? !x_eba[0] : 1'b1;
    lane_hi = x_byte ? x_eba[0] : 1'b1;
    if (x_wr_ok && x_wm[4])
    begin
      if (lane_lo)
        nxt_st.wreg[x_wm[3:0]][7:0] = x_wdata[7:0];
      if (lane_hi)
        nxt_st.wreg[x_wm[3:0]][15:8] = x_byte ? x_wdata[7:0] : x_wdata[15:8];
    end
    if (x_wr_ok && region_of(x_eba) == dsa_pkg::RG_RAM)
    begin
      cpu_we_lo = lane_lo;
      cpu_we_hi = lane_hi;
      cpu_widx = ram_idx(x_eba);
      cpu_wword = {x_byte ? x_wdata[7:0] : x_wdata[15:8], x_wdata[7:0]};
    end

    // x address generator: post-increment scaled to size, bit-reversed step on writes when x_brev_en is set
    if (x_req && x_amode == dsa_pkg::AM_POSTINC)
    begin
      if (x_write && x_brev_en)
        nxt_st.wreg[x_ptr_sel] = brev_next(x_ptr, x_brev_step);
      else
        nxt_st.wreg[x_ptr_sel] = mod_next(x_ptr, x_byte ? `DSA_BYTE_STEP : `DSA_WORD_STEP,
                                          x_mod_en, x_mod_start, x_mod_end);
    end

    // load of read data into a working register
    if (x_req && !x_write && x_load_en)
    begin
      if (x_byte)
        nxt_st.wreg[x_load_sel][7:0] = x_val[7:0];
      else
        nxt_st.wreg[x_load_sel] = x_val;
    end

    // extend operations
    ext_src = st_ff.wreg[ext_sel];
    case (ext_op)
      dsa_pkg::EXT_SIGN: nxt_st.wreg[ext_sel] = {{8{ext_src[7]}}, ext_src[7:0]};
      dsa_pkg::EXT_ZERO: nxt_st.wreg[ext_sel] = {8'h00, ext_src[7:0]};
      default: ;
    endcase

    // y address generator and second read path, y space only
    y_eba = st_ff.wreg[y_ptr_sel];
    if (y_eba >= Y_BASE && y_eba < RAM_END)
      y_word = {mem_hi[ram_idx(y_eba)], mem_lo[ram_idx(y_eba)]};
    else
      y_word = 16'h0000;
    if (y_req)
    begin
      nxt_st.y_rdata = y_word;
      nxt_st.y_rvalid = 1'b1;
      if (y_postinc)
        nxt_st.wreg[y_ptr_sel] = mod_next(y_eba, `DSA_WORD_STEP, y_mod_en, y_mod_start, y_mod_end);
    end

    // dma port on the top of y space
    dma_idx = ram_idx(DMA_BASE) + AW'(dma_word);
    if (dma_req && !dma_write)
    begin
      nxt_st.dma_rdata = {mem_hi[dma_idx], mem_lo[dma_idx]};
      nxt_st.dma_rvalid = 1'b1;
    end
    if (dma_req && dma_write)
    begin
      // a lane the cpu writes this cycle is lost for dma
      dma_we_lo = dma_be[0] && !(cpu_we_lo && cpu_widx == dma_idx);
      dma_we_hi = dma_be[1] && !(cpu_we_hi && cpu_widx == dma_idx);
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
      st_ff.wreg[15] <= `DSA_WREG15_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // memory halves, cpu and dma ports, independent lanes
  always_ff @(posedge clk_sys)
  begin
    if (dma_we_lo)
      mem_lo[dma_idx] <= dma_wdata[7:0];
    if (dma_we_hi)
      mem_hi[dma_idx] <= dma_wdata[15:8];
    if (cpu_we_lo)
      mem_lo[cpu_widx] <= cpu_wword[7:0];
    if (cpu_we_hi)
      mem_hi[cpu_widx] <= cpu_wword[15:8];
  end

  // ==========================================================
  // outputs straight from the state register
  assign x_rdata = st_ff.x_rdata;
  assign x_rvalid = st_ff.x_rvalid;
  assign y_rdata = st_ff.y_rdata;
  assign y_rvalid = st_ff.y_rvalid;
  assign dma_rdata = st_ff.dma_rdata;
  assign dma_rvalid = st_ff.dma_rvalid;
  assign addr_err = st_ff.addr_err;
  assign addr_err_wr = st_ff.addr_err_wr;
  assign psv_sel = st_ff.psv_sel;
  assign psv_addr = st_ff.psv_addr;

endmodule

`default_nettype wire

// ---- rtl/dsa_pkg.sv ----
// types shared by the data space access unit
package dsa_pkg;

  // ==========================================================
  // x address source
  typedef enum logic [1:0] {AM_DIRECT16, AM_NEAR13, AM_INDIRECT, AM_POSTINC} dsa_amode_t;

  // working register extend operations
  typedef enum logic [1:0] {EXT_NONE, EXT_SIGN, EXT_ZERO} dsa_ext_t;

  // decoded region of an effective address
  typedef enum logic [1:0] {RG_SPEC, RG_RAM, RG_NONE, RG_PSV} dsa_region_t;

  // ==========================================================
  // registered state of the unit apart from the two ram halves
  typedef struct packed {
    logic [15:0][15:0] wreg;
    logic [15:0] x_rdata;
    logic x_rvalid;
    logic [15:0] y_rdata;
    logic y_rvalid;
    logic [15:0] dma_rdata;
    logic dma_rvalid;
    logic addr_err;
    logic addr_err_wr;
    logic psv_sel;
    logic [14:0] psv_addr;
  } dsa_state_t;

endpackage

// ---- rtl/dsa_regs.svh ----
// register offsets, reset values and address map constants for the data space access unit
`ifndef DSA_REGS_SVH
`define DSA_REGS_SVH

// ==========================================================
// working register offsets in data space
`define DSA_WORK_REG_0_OFS 16'h0000
`define DSA_WORK_REG_1_OFS 16'h0002
`define DSA_WORK_REG_2_OFS 16'h0004
`define DSA_WORK_REG_3_OFS 16'h0006
`define DSA_WORK_REG_4_OFS 16'h8000
`define DSA_WORK_REG_5_OFS 16'h000a
`define DSA_WORK_REG_6_OFS 16'h000c
`define DSA_WORK_REG_7_OFS 16'h000e
`define DSA_WORK_REG_8_OFS 16'h0010
`define DSA_WORK_REG_9_OFS 16'h0012
`define DSA_WORK_REG_10_OFS 16'h0014

// ==========================================================
// reset values
`define DSA_WREG_RST 16'h0000
`define DSA_WREG15_RST 16'h0800

// ==========================================================
// address map
`define DSA_SPEC_LAST 16'h07ff
`define DSA_NEAR_BITS 13
`define DSA_RAM_BASE 16'h0800
`define DSA_RAM_BYTES 16'h2000
`define DSA_Y_BASE 16'h1800
`define DSA_DMA_BYTES 16'h0800
`define DSA_DMA_WORD_BITS 10

// ==========================================================
// pointer steps
`define DSA_BYTE_STEP 16'h0001
`define DSA_WORD_STEP 16'h0002

`endif

// ---- test/dsa_access_unit_assertions.sv ----
// port checker for the data space access unit
`timescale 1ns/1ps
`default_nettype none
`include "dsa_regs.svh"

module dsa_access_unit_chk #(
  parameter logic [15:0] RAM_BYTES = `DSA_RAM_BYTES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic x_req,
  input wire logic x_write,
  input wire logic x_byte,
  input wire dsa_pkg::dsa_amode_t x_amode,
  input wire logic [15:0] x_direct_addr,
  input wire logic y_req,
  input wire logic dma_req,
  input wire logic dma_write,
  input wire logic [15:0] x_rdata,
  input wire logic x_rvalid,
  input wire logic y_rvalid,
  input wire logic dma_rvalid,
  input wire logic addr_err,
  input wire logic addr_err_wr,
  input wire logic psv_sel,
  input wire logic [14:0] psv_addr
);
  // ==========================================================
  // one clock domain, reset disables all
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  wire logic dir_rd = x_req && !x_write && x_amode == dsa_pkg::AM_DIRECT16;

  chk_odd_word_err: assert property (
    x_req && !x_byte && x_amode == dsa_pkg::AM_DIRECT16 && x_direct_addr[0] |=> addr_err)
    else $error("odd word access gave no address error");
  chk_err_cause_dir: assert property (
    addr_err |-> $past(x_req && !x_byte) && addr_err_wr == $past(x_write))
    else $error("address error without word access or wrong direction");
  chk_rvalid_cause: assert property (
    x_rvalid == $past(x_req && !x_write))
    else $error("x read answer not one cycle after read");
  chk_byte_lane_low: assert property (
    x_req && !x_write && x_byte |=> x_rdata[15:8] == 8'h00)
    else $error("byte read upper lane not zero");
  chk_spec_unused_zero: assert property (
    dir_rd && x_direct_addr inside {[16'h0016:16'h07ff]} |=> x_rdata == 16'h0000)
    else $error("unused register address read not zero");
  chk_unimpl_zero: assert property (
    dir_rd && x_direct_addr inside {[`DSA_RAM_BASE + RAM_BYTES:16'h7fff]} |=> x_rdata == 16'h0000)
    else $error("unimplemented address read not zero");
  chk_psv_route: assert property (
    x_req && x_amode == dsa_pkg::AM_DIRECT16 && x_direct_addr[15] && x_direct_addr[15:1] != 15'h4000
    |=> psv_sel && psv_addr == $past(x_direct_addr[14:0]))
    else $error("upper half address not routed to program view");
  chk_y_answer: assert property (
    y_req |=> y_rvalid)
    else $error("y read not answered");
  chk_dma_answer: assert property (
    dma_req && !dma_write |=> dma_rvalid)
    else $error("dma read not answered");
endmodule

bind dsa_access_unit dsa_access_unit_chk #(.RAM_BYTES(RAM_BYTES)) i_dsa_access_unit_chk (
  .clk_sys, .nrst, .x_req, .x_write, .x_byte, .x_amode, .x_direct_addr, .y_req, .dma_req,
  .dma_write, .x_rdata, .x_rvalid, .y_rvalid, .dma_rvalid, .addr_err, .addr_err_wr, .psv_sel,
  .psv_addr
);

`default_nettype wire

// ---- test/dsa_dma_model.sv ----
// dma controller model on the dma ram port
`timescale 1ns/1ps
`default_nettype none
`include "dsa_regs.svh"

module dsa_dma_model (
  input wire logic clk_sys,
  output logic dma_req,
  output logic dma_write,
  output logic [`DSA_DMA_WORD_BITS-1:0] dma_word,
  output logic [1:0] dma_be,
  output logic [15:0] dma_wdata,
  input wire logic [15:0] dma_rdata,
  input wire logic dma_rvalid
);
  logic [15:0] rd_val;
  logic rd_ok;

  // idle port at time zero
  initial
  begin
    dma_req = 1'b0;
    dma_write = 1'b0;
    dma_word = '0;
    dma_be = 2'h0;
    dma_wdata = 16'h0000;
  end

  // one request cycle on the own port, never waits on the cpu
  task automatic op(input logic w, input logic [`DSA_DMA_WORD_BITS-1:0] a, input logic [1:0] be,
    input logic [15:0] d);
    @(posedge clk_sys);
    dma_req <= 1'b1;
    dma_write <= w;
    dma_word <= a;
    dma_be <= be;
    dma_wdata <= d;
    @(posedge clk_sys);
    dma_req <= 1'b0;
    dma_wdata <= ~d;
    #1;
    rd_val = dma_rdata;
    rd_ok = dma_rvalid;
  endtask
endmodule

`default_nettype wire

// ---- test/tb_dsa_access_unit.sv ----
// self-checking bench for the data space access unit
`timescale 1ns/1ps
`default_nettype none

module tb_dsa_access_unit;
  localparam dsa_pkg::dsa_amode_t am_dir = dsa_pkg::AM_DIRECT16;
  localparam dsa_pkg::dsa_amode_t am_inc = dsa_pkg::AM_POSTINC;
  logic clk_sys, nrst, x_req, x_write, x_byte, x_load_en, y_req, y_postinc, x_mod_en, y_mod_en, x_brev_en;
  dsa_pkg::dsa_amode_t x_amode;
  dsa_pkg::dsa_ext_t ext_op;
  logic [15:0] x_direct_addr, x_wdata, x_mod_start, x_mod_end, y_mod_start, y_mod_end;
  logic [3:0] x_ptr_sel, x_load_sel, ext_sel, y_ptr_sel;
  logic [14:0] x_brev_step, psv_addr;
  logic [15:0] x_rdata, y_rdata, dma_rdata, dma_wdata;
  logic x_rvalid, y_rvalid, dma_rvalid, addr_err, addr_err_wr, psv_sel, dma_req, dma_write;
  logic [9:0] dma_word;
  logic [1:0] dma_be;
  int num_errors = 0;
  int tests_run = 0;

  // ==========================================================
  // design and dma model
  dsa_access_unit i_dsa_access_unit (
    .clk_sys, .nrst, .x_req, .x_write, .x_byte, .x_amode, .x_direct_addr, .x_ptr_sel, .x_wdata,
    .x_load_en, .x_load_sel, .ext_op, .ext_sel, .y_req, .y_ptr_sel, .y_postinc, .x_mod_en,
    .x_mod_start, .x_mod_end, .y_mod_en, .y_mod_start, .y_mod_end, .x_brev_en, .x_brev_step,
    .dma_req, .dma_write, .dma_word, .dma_be, .dma_wdata, .x_rdata, .x_rvalid, .y_rdata,
    .y_rvalid, .dma_rdata, .dma_rvalid, .addr_err, .addr_err_wr, .psv_sel, .psv_addr
  );
  dsa_dma_model i_dsa_dma_model (
    .clk_sys, .dma_req, .dma_write, .dma_word, .dma_be, .dma_wdata, .dma_rdata, .dma_rvalid
  );

  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one x access, answer sampled after the taking edge
  task automatic xa(input logic w, input logic b, input dsa_pkg::dsa_amode_t am, input logic [15:0] a,
    input logic [15:0] d, input logic [3:0] p = 4'h0, input logic ld = 1'b0, input logic yr = 1'b0);
    @(posedge clk_sys);
    x_req <= 1'b1;
    x_write <= w;
    x_byte <= b;
    x_amode <= am;
    x_direct_addr <= a;
    x_wdata <= d;
    x_ptr_sel <= p;
    x_load_sel <= p;
    x_load_en <= ld;
    y_req <= yr;
    @(posedge clk_sys);
    x_req <= 1'b0;
    x_load_en <= 1'b0;
    y_req <= 1'b0;
    x_wdata <= ~d;
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    xa(1'b1, 1'b0, am_dir, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    xa(1'b0, 1'b0, am_dir, a, 16'h0000);
    chk(x_rdata, exp);
  endtask

  task automatic ext(input dsa_pkg::dsa_ext_t e);
    @(posedge clk_sys);
    ext_op <= e;
    ext_sel <= 4'h3;
    @(posedge clk_sys);
    ext_op <= dsa_pkg::EXT_NONE;
  endtask

  task automatic summarize();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #200000;
    num_errors++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {nrst, x_req, x_write, x_byte, x_load_en, y_req, y_postinc, x_mod_en, y_mod_en, x_brev_en} = '0;
    {x_direct_addr, x_wdata, x_mod_start, x_mod_end, y_mod_start, y_mod_end} = '0;
    {x_ptr_sel, x_load_sel, ext_sel, y_ptr_sel, x_brev_step} = '0;
    x_amode = am_dir;
    ext_op = dsa_pkg::EXT_NONE;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 11; i++)
      if (i != 4) rd(16'(2 * i), 16'h0000);
    rd(16'h8000, 16'h0000);
    wr(16'h0800, 16'h1234);
    xa(1'b1, 1'b1, am_dir, 16'h0801, 16'h00ab);
    rd(16'h0800, 16'hab34);
    xa(1'b0, 1'b1, am_dir, 16'h0800, 16'h0000);
    chk(x_rdata, 16'h0034);
    xa(1'b0, 1'b1, am_dir, 16'h0801, 16'h0000);
    chk(x_rdata, 16'h00ab);
    wr(16'h0802, 16'h5566);
    xa(1'b1, 1'b0, am_dir, 16'h0803, 16'hffff);
    chk({14'h0, addr_err, addr_err_wr}, 16'h0003);
    rd(16'h0802, 16'h5566);
    xa(1'b0, 1'b0, am_dir, 16'h0801, 16'h0000);
    chk(x_rdata, 16'hab34);
    chk({14'h0, addr_err, addr_err_wr}, 16'h0002);
    wr(16'h0002, 16'h0800);
    xa(1'b0, 1'b1, am_inc, 16'h0000, 16'h0000, 4'h1);
    rd(16'h0002, 16'h0801);
    wr(16'h0004, 16'h0800);
    xa(1'b0, 1'b0, am_inc, 16'h0000, 16'h0000, 4'h2);
    rd(16'h0004, 16'h0802);
    wr(16'h0006, 16'h1234);
    xa(1'b0, 1'b1, am_dir, 16'h0801, 16'h0000, 4'h3, 1'b1);
    rd(16'h0006, 16'h12ab);
    ext(dsa_pkg::EXT_SIGN);
    rd(16'h0006, 16'hffab);
    ext(dsa_pkg::EXT_ZERO);
    rd(16'h0006, 16'h00ab);
    wr(16'h0100, 16'hffff);
    rd(16'h0100, 16'h0000);
    rd(16'h3000, 16'h0000);
    xa(1'b0, 1'b0, dsa_pkg::AM_NEAR13, 16'he800, 16'h0000);
    chk(x_rdata, 16'hab34);
    xa(1'b0, 1'b0, am_dir, 16'h9234, 16'h0000);
    chk({psv_sel, psv_addr}, 16'h9234);
    wr(16'h000a, 16'h0800);
    xa(1'b0, 1'b0, dsa_pkg::AM_INDIRECT, 16'h0000, 16'h0000, 4'h5);
    chk(x_rdata, 16'hab34);
    // modulo windows on both generators
    wr(16'h1800, 16'hbeef);
    wr(16'h0010, 16'h1800);
    @(posedge clk_sys);
    x_mod_en <= 1'b1;
    x_mod_start <= 16'h0800;
    x_mod_end <= 16'h0803;
    y_mod_en <= 1'b1;
    y_mod_start <= 16'h1800;
    y_mod_end <= 16'h1801;
    y_ptr_sel <= 4'h8;
    y_postinc <= 1'b1;
    xa(1'b0, 1'b0, am_inc, 16'h0000, 16'h0000, 4'h2, 1'b0, 1'b1);
    chk(x_rdata, 16'h5566);
    chk(y_rdata, 16'hbeef);
    rd(16'h0004, 16'h0800);
    rd(16'h0010, 16'h1800);
    // bit-reversed pointer update on an x write
    wr(16'h000c, 16'h0808);
    @(posedge clk_sys);
    x_brev_en <= 1'b1;
    x_brev_step <= 15'h0004;
    xa(1'b1, 1'b0, am_inc, 16'h0000, 16'h4321, 4'h6);
    rd(16'h000c, 16'h0804);
    rd(16'h0808, 16'h4321);
    // dma ram shared with the cpu
    i_dsa_dma_model.op(1'b1, 10'h000, 2'h3, 16'h1111);
    rd(16'h2000, 16'h1111);
    wr(16'h2002, 16'h2222);
    i_dsa_dma_model.op(1'b0, 10'h001, 2'h0, 16'h0000);
    chk(i_dsa_dma_model.rd_val, 16'h2222);
    chk({15'h0, i_dsa_dma_model.rd_ok}, 16'h0001);
    fork
      xa(1'b1, 1'b0, am_dir, 16'h2004, 16'hcccc);
      i_dsa_dma_model.op(1'b1, 10'h002, 2'h3, 16'hdddd);
    join
    rd(16'h2004, 16'hcccc);
    fork
      xa(1'b1, 1'b1, am_dir, 16'h2006, 16'h0077);
      i_dsa_dma_model.op(1'b1, 10'h003, 2'h3, 16'h8899);
    join
    rd(16'h2006, 16'h8877);
    summarize();
  end
endmodule

`default_nettype wire
